// ---- rtl/usb_termination_state_decoder.sv ----
// termination state decoder with its axi4-lite control registers
//
// Behaviour
// - enables follow only the five control fields
// - host low speed/suspend: pull-downs only
// - host low speed resume: pull-downs only
// - otg chirp: dp pull-up, dm pull-down
// - otg high speed: hs termination, dm pull-down
// - otg full speed: dp pull-up, dm pull-down
// - otg suspend: dp pull-up, dm pull-down
// - otg resume: dp pull-up, dm pull-down
// - otg test j/k: hs termination, dm pull-down
`timescale 1ns/100ps
`include "term_decoder_consts.svh"

module usb_termination_state_decoder
(
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_enable,
	// axi4-lite write
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// termination enables
	output term_decoder_pkg::term_enables_t term_en
);
	term_decoder_pkg::xcvr_ctrl_t ctrl_reg;
	term_decoder_pkg::term_enables_t term_next;
	logic wr_fire;
	logic rd_fire;

	assign wr_fire = awvalid && awready && wvalid && wready;
	assign rd_fire = arvalid && arready;

	// write address and data are taken together, one cycle after both show
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b0;
			wready <= 1'b0;
		end
		else if (clk_enable)
		begin
			awready <= awvalid && wvalid && !awready && !bvalid;
			wready <= awvalid && wvalid && !wready && !bvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp <= `TD_RESP_OKAY;
		end
		else if (clk_enable)
		begin
			if (wr_fire)
			begin
				bvalid <= 1'b1;
				if ({awaddr[3:2], 2'h0} == `TD_CTRL_OFFSET ||
					{awaddr[3:2], 2'h0} == `TD_STATUS_OFFSET)
					bresp <= `TD_RESP_OKAY;
				else
					bresp <= `TD_RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// only the control word steers the decode; status writes are dropped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_reg <= `TD_CTRL_RESET;
		else if (clk_enable && wr_fire && wstrb[0] &&
			{awaddr[3:2], 2'h0} == `TD_CTRL_OFFSET)
			ctrl_reg <= wdata[6:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			arready <= 1'b0;
		else if (clk_enable)
			arready <= arvalid && !arready && !rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `TD_RESP_OKAY;
		end
		else if (clk_enable)
		begin
			if (rd_fire)
			begin
				rvalid <= 1'b1;
				rresp <= `TD_RESP_OKAY;
				case (araddr[3:2])
					2'h0: rdata <= {25'h0, ctrl_reg};
					2'h1: rdata <= {27'h0, term_en};
					default:
					begin
						rdata <= 32'h0000_0000;
						rresp <= `TD_RESP_SLVERR;
					end
				endcase
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	// pull-downs follow the link's requests outside no-drive mode, and a dp pull-down request blocks
	// the dp pull-up, so host never gets one; dm pull-up is never asked for here
	always_comb
	begin
		term_next.dp_pulldown_enable = ctrl_reg.dp_pulldown;
		term_next.dm_pulldown_enable = ctrl_reg.dm_pulldown;
		term_next.hs_term_enable = ctrl_reg.xcvr_select == `TD_XCVR_HS &&
			!ctrl_reg.term_select;
		term_next.dp_pullup_enable = ctrl_reg.term_select &&
			!ctrl_reg.dp_pulldown;
		term_next.dm_pullup_enable = 1'b0;
		if (ctrl_reg.op_mode == `TD_OPMODE_NODRIVE)
			term_next = '0;
	end

	// registered so the analog switches never see decode glitches
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			term_en <= `TD_ENABLES_RESET;
		else if (clk_enable)
			term_en <= term_next;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence ctrl_held;
		clk_enable && $stable(ctrl_reg);
	endsequence

	AST_FIELDS_ONLY: assert property (
		clk_enable ##1 ctrl_held |=> $stable(term_en))
		else $error("enables moved with fields unchanged");

	AST_NODRIVE: assert property (
		clk_enable && ctrl_reg.op_mode == `TD_OPMODE_NODRIVE
		|=> term_en == 5'h00)
		else $error("no-drive mode left an enable on");

	AST_POWERUP: assert property (
		clk_enable && ctrl_reg == 7'h61 |=> term_en == 5'h06)
		else $error("power-up state decode wrong");

	AST_HOST_LS: assert property (
		clk_enable && ctrl_reg == 7'h66 |=> term_en == 5'h06)
		else $error("host low speed decode wrong");

	AST_HOST_LS_RESUME: assert property (
		clk_enable && ctrl_reg == 7'h76 |=> term_en == 5'h06)
		else $error("host low speed resume decode wrong");

	AST_OTG_CHIRP: assert property (
		clk_enable && ctrl_reg == 7'h54 |=> term_en == 5'h12)
		else $error("otg chirp decode wrong");

	AST_OTG_HS: assert property (
		clk_enable && ctrl_reg == 7'h40 |=> term_en == 5'h03)
		else $error("otg high speed decode wrong");

	AST_OTG_FS: assert property (
		clk_enable && ctrl_reg == 7'h45 |=> term_en == 5'h12)
		else $error("otg full speed or suspend decode wrong");

	AST_OTG_RESUME: assert property (
		clk_enable && ctrl_reg == 7'h55 |=> term_en == 5'h12)
		else $error("otg resume decode wrong");

	AST_OTG_TEST: assert property (
		clk_enable && ctrl_reg == 7'h50 |=> term_en == 5'h03)
		else $error("otg test j/k decode wrong");

	AST_HOST_HS: assert property (
		clk_enable && ctrl_reg == 7'h60 |=> term_en == 5'h07)
		else $error("host high speed decode wrong");

	AST_HOST_CHIRP: assert property (
		clk_enable && ctrl_reg == 7'h70 |=> term_en == 5'h07)
		else $error("host chirp or test decode wrong");

	AST_PERIPH_FS: assert property (
		clk_enable && ctrl_reg == 7'h05 |=> term_en == 5'h10)
		else $error("peripheral full speed decode wrong");

	AST_WRITE_TO_ENABLE: assert property (
		clk_enable && wr_fire && wstrb[0] && awaddr == `TD_CTRL_OFFSET
		&& wdata[4:3] == 2'h1 ##1 clk_enable |=> term_en == 5'h00)
		else $error("written no-drive mode not seen two cycles on");
endmodule

// ---- include/term_decoder_consts.svh ----
// constants for the termination decoder: offsets, fields, reset values
`ifndef TERM_DECODER_CONSTS_SVH
`define TERM_DECODER_CONSTS_SVH
`define TD_CTRL_OFFSET 4'h0
`define TD_STATUS_OFFSET 4'h4
`define TD_XCVR_LSB 0
`define TD_TERM_BIT 2
`define TD_OPMODE_LSB 3
`define TD_DPPD_BIT 5
`define TD_DMPD_BIT 6
`define TD_CTRL_RESET 7'h61
`define TD_ENABLES_RESET 5'h06
`define TD_OPMODE_NORMAL 2'h0
`define TD_OPMODE_NODRIVE 2'h1
`define TD_OPMODE_CHIRP 2'h2
`define TD_XCVR_HS 2'h0
`define TD_RESP_OKAY 2'h0
`define TD_RESP_SLVERR 2'h2
`endif

// ---- include/term_decoder_pkg.sv ----
// types shared by the termination decoder
package term_decoder_pkg;
	typedef struct packed {
		logic dm_pulldown;
		logic dp_pulldown;
		logic [1:0] op_mode;
		logic term_select;
		logic [1:0] xcvr_select;
	} xcvr_ctrl_t;
	typedef struct packed {
		logic dp_pullup_enable;
		logic dm_pullup_enable;
		logic dp_pulldown_enable;
		logic dm_pulldown_enable;
		logic hs_term_enable;
	} term_enables_t;
endpackage

// ---- tb/link_master.sv ----
// link controller model: axi4-lite master
`timescale 1ns/100ps
module link_master
(
	// clock, status
	input wire logic aclk,
	output logic hung,
	// write
	output logic [3:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// read
	output logic [3:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial
	begin
		{hung, awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'hF;
	end
	// each task lets an edge pass first, so no signal is set twice at once
	// once a wait has run out, every later call returns at once
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		int i;
		r = 2'h3;
		if (hung)
			return;
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid, bready} <= 3'h7;
		for (i = 0; i < 20; i++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				{wdata, wvalid} <= {~d, 1'b0};
			if (bvalid)
				break;
		end
		r = bresp;
		bready <= 1'b0;
		hung <= hung | (i == 20);
	endtask
	task automatic rd(input logic [3:0] a, output logic [33:0] d);
		int i;
		d = '1;
		if (hung)
			return;
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		for (i = 0; i < 20; i++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		d = {rresp, rdata};
		rready <= 1'b0;
		hung <= hung | (i == 20);
	endtask
endmodule

// ---- tb/usb_termination_state_decoder_tb.sv ----
// testbench for the termination state decoder
`timescale 1ns/100ps
module usb_termination_state_decoder_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic clk_enable = 1'b1;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [33:0] got;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, hung;
	term_decoder_pkg::term_enables_t term_en;
	int fail_count = 0;
	int n_tests = 0;
	always #50 aclk = ~aclk;
	usb_termination_state_decoder i_dut (.*);
	link_master u_link (.*);
	task automatic check(input logic [33:0] g, input logic [33:0] e);
		n_tests++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic test_done;
		fail_count += hung;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// write a control setting, then check the enables at the port and in
	// the status word, which lags control by one cycle
	task automatic apply(input logic [31:0] c, input logic [4:0] e);
		logic [1:0] r;
		u_link.wr(4'h0, c, 4'hF, r);
		@(negedge aclk);
		check(34'(term_en), 34'(e));
		check(34'(r), 34'h0);
		u_link.rd(4'h4, got);
		check(got, 34'(e));
	endtask
	task automatic test_power_up;
		@(negedge aclk);
		check(34'(term_en), 34'h06);
		u_link.rd(4'h0, got);
		check(got, 34'h61);
		u_link.rd(4'h4, got);
		check(got, 34'h06);
		$display("test power up done");
	endtask
	// op mode 11 is not a no-drive code and decodes like normal
	task automatic test_nodrive;
		apply(32'h6C, 5'h00);
		apply(32'h6D, 5'h00);
		apply(32'h7D, 5'h06);
		$display("test nodrive done");
	endtask
	task automatic test_host;
		apply(32'h66, 5'h06);
		apply(32'h76, 5'h06);
		apply(32'h60, 5'h07);
		apply(32'h70, 5'h07);
		apply(32'h67, 5'h06);
		$display("test host done");
	endtask
	task automatic test_otg;
		apply(32'h54, 5'h12);
		apply(32'h40, 5'h03);
		apply(32'h45, 5'h12);
		apply(32'h45, 5'h12);
		apply(32'h55, 5'h12);
		apply(32'h50, 5'h03);
		$display("test otg done");
	endtask
	task automatic test_periph;
		apply(32'h14, 5'h10);
		apply(32'h00, 5'h01);
		apply(32'h05, 5'h10);
		apply(32'h10, 5'h01);
		$display("test periph done");
	endtask
	// status word, cleared strobe and unmapped word leave control alone
	task automatic test_ignored_writes;
		logic [1:0] r;
		apply(32'h66, 5'h06);
		u_link.wr(4'h4, 32'h1F, 4'hF, r);
		check(34'(r), 34'h0);
		u_link.wr(4'h0, 32'h1F, 4'h0, r);
		check(34'(r), 34'h0);
		u_link.wr(4'h8, 32'h1F, 4'hF, r);
		check(34'(r), 34'h2);
		@(negedge aclk);
		check(34'(term_en), 34'h06);
		u_link.rd(4'h0, got);
		check(got, 34'h66);
		u_link.rd(4'h8, got);
		check(got, 34'h2_0000_0000);
		$display("test ignored writes done");
	endtask
	// a write offered while frozen must wait, not be lost
	task automatic test_freeze;
		logic [1:0] r;
		apply(32'h54, 5'h12);
		@(posedge aclk);
		clk_enable <= 1'b0;
		fork
			u_link.wr(4'h0, 32'h40, 4'hF, r);
			begin
				repeat (4) @(negedge aclk);
				check(34'(term_en), 34'h12);
				@(posedge aclk);
				clk_enable <= 1'b1;
			end
		join
		@(negedge aclk);
		check(34'(term_en), 34'h03);
		check(34'(r), 34'h0);
		$display("test freeze done");
	endtask
	// reset must win over a frozen enable and restore power-up state
	task automatic test_mid_reset;
		apply(32'h54, 5'h12);
		@(posedge aclk);
		aresetn <= 1'b0;
		clk_enable <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		clk_enable <= 1'b1;
		@(negedge aclk);
		check(34'(term_en), 34'h06);
		u_link.rd(4'h0, got);
		check(got, 34'h61);
		$display("test mid reset done");
	endtask
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		test_power_up();
		test_nodrive();
		test_host();
		test_otg();
		test_periph();
		test_ignored_writes();
		test_freeze();
		test_mid_reset();
		test_done();
	end
endmodule
